// File: hdl/icsm_pkg.sv
package icsm_pkg;

	// Clock and timing
	localparam longint CLK_HZ          = 64'd10000000;
	localparam longint REFRESH_S       = 64'd10;      // Flow status refresh, current-info view
	localparam longint DAY_S           = 64'd86400;   // Flow status refresh, normal
	localparam longint BLINK_HALF_MS   = 64'd500;     // Half period of the flashing lamp
	localparam longint REFRESH_CYC     = REFRESH_S * CLK_HZ;
	localparam longint DAY_CYC         = DAY_S * CLK_HZ;
	localparam longint BLINK_HALF_CYC  = (BLINK_HALF_MS * CLK_HZ) / 64'd1000;
	localparam int     TMR_W           = 40;

	// Info log sizing
	localparam int       LOG_DEPTH     = 250;
	localparam int       LOG_VIEW      = 50;
	localparam int       LOG_PTR_W     = 8;
	localparam bit [7:0] LOG_LAST      = 8'hf9;       // Index 249
	localparam bit [7:0] LOG_DEPTH_8   = 8'hfa;
	localparam bit [7:0] LOG_VIEW_8    = 8'h32;

	// Status word bit positions
	localparam int B_SUPPLY = 0,  B_LOWBAT = 1,  B_EXTALM = 2;
	localparam int B_T1_HI  = 3,  B_T2_HI  = 4,  B_T1_LO  = 5,  B_T2_LO = 6,  B_DT_BAD = 7;
	localparam int B_F1_AIR = 8,  B_F1_REV = 9,  B_F1_OVR = 11, B_F1_COM = 16, B_F1_PUL = 17;
	localparam int B_F2_AIR = 24, B_F2_REV = 25, B_F2_OVR = 27, B_F2_COM = 22, B_F2_PUL = 23;
	localparam int B_A1_LK  = 12, B_B1_LK  = 13, B_A_ALM  = 14, B_B_ALM  = 15;
	localparam int B_A2_LK  = 18, B_B2_LK  = 19, B_T3_HI  = 20, B_T3_LO  = 21;
	localparam int B_BURST_LOSS = 28, B_BURST_PEN = 29, B_LEAK_LOSS = 30, B_LEAK_PEN = 31;

	// Forced serial values (0.01 degC, 0.01 K, 0.1 kW)
	localparam bit [15:0] TEMP_FORCED_HI = 16'h4844;  // 185,00
	localparam bit [15:0] TEMP_FORCED_LO = 16'h0000;  // 0,00
	localparam bit [15:0] DIFF_FORCED    = 16'h0000;
	localparam bit [23:0] POWER_FORCED   = 24'h000000;
	localparam bit [31:0] WORD_RESET     = 32'h00000000;

	// Flow sensor fault group
	typedef struct packed {
		logic air;
		logic reverse;
		logic over_flow;
		logic comm_err;
		logic pulse_fig;
	} icsm_flow_st_t;

	// All pin-side inputs, synchronised together
	typedef struct packed {
		logic          supply_present;
		logic          low_battery;
		logic          ext_alarm;
		logic [2:0]    temp_above;
		logic [2:0]    temp_below;
		logic          diff_wrong;
		icsm_flow_st_t first_flow_sensor;
		icsm_flow_st_t second_flow_sensor;
		logic          burst_loss;
		logic          burst_pen;
		logic          leak_loss;
		logic          leak_pen;
		logic          pair_a_first_input;
		logic          pair_a_second_input;
		logic          pair_b_first_input;
		logic          pair_b_second_input;
		logic          pair_a_alarm;
		logic          pair_b_alarm;
		logic          flow_min_seen;
		logic          end_configuration_command;
		logic          cfg_radio_enable;
		logic          both_arrow_keys;
		logic          test_loop;
		logic          info_view_sel;
		logic          pair_b_leak_sel;
	} icsm_pins_t;

	// Log time stamp
	typedef struct packed {
		logic [7:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} icsm_stamp_t;

	// One info log record
	typedef struct packed {
		icsm_stamp_t stamp;
		logic [31:0] info;
		logic [31:0] heat_energy_register;
		logic [31:0] cooling_energy_register;
	} icsm_log_rec_t;

endpackage : icsm_pkg

// File: hdl/icsm_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module icsm_monitor
	import icsm_pkg::*;
#(
	parameter longint DAY_CYCLES     = DAY_CYC,
	parameter longint REFRESH_CYCLES = REFRESH_CYC,
	parameter longint BLINK_CYCLES   = BLINK_HALF_CYC
) (
	input  wire logic          clk_sys,
	input  wire logic          srst,
	input  wire icsm_pins_t    pins_async,
	input  wire icsm_stamp_t   now_stamp,
	input  wire logic [31:0]   heat_energy_register,
	input  wire logic [31:0]   cooling_energy_register,
	input  wire logic [15:0]   temp_meas [3],
	input  wire logic [15:0]   diff_meas,
	input  wire logic [23:0]   power_meas,
	input  wire logic [7:0]    log_rd_age,
	output logic [31:0]        fault_status_word,
	output logic               info_lamp,
	output logic [31:0]        info_event_count,
	output logic               transport_state,
	output logic               power_saving_seq,
	output logic               config_access,
	output logic               radio_on,
	output logic [15:0]        temp_report [3],
	output logic [15:0]        diff_report,
	output logic [23:0]        power_report,
	output logic [2:0]         temp_blank,
	output logic               power_blank,
	output logic               heat_accum_en,
	output logic               cool_accum_en,
	output logic [7:0]         log_count,
	output logic [7:0]         log_view_count,
	output icsm_log_rec_t      log_rd_data
);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	icsm_pins_t    pins_meta_reg, pins_reg, pins_d_reg;
	icsm_flow_st_t flow1_reg, flow2_reg;
	logic [31:0]   word_next, word_reg, prev_word_reg;
	logic          change_evt, supply_back, end_cfg_evt, call_evt, view_rise;
	logic          transport_reg, radio_reg, blink_reg;
	logic [TMR_W-1:0] refresh_cnt_reg, blink_cnt_reg;
	logic          refresh_tick;
	icsm_log_rec_t log_mem [LOG_DEPTH];
	logic [7:0]    wr_ptr_reg;
	logic          log_wr;

	// Ring index of the record that is age steps older than the newest
	function automatic logic [7:0] ring_back(input logic [7:0] ptr, input logic [7:0] back);
		logic [8:0] idx;
		idx = {1'b0, ptr} + {1'b0, LOG_DEPTH_8} - 9'h001 - {1'b0, back};
		if (idx >= {1'b0, LOG_DEPTH_8}) begin
			idx = idx - {1'b0, LOG_DEPTH_8};
		end
		return idx[7:0];
	endfunction : ring_back

	// Two-stage synchroniser for all pin inputs, plus a delayed copy for edges
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			// Supply resets to its idle level (present) so release shows no false return edge
			pins_meta_reg                <= '0;
			pins_meta_reg.supply_present <= 1'b1;
			pins_reg                     <= '0;
			pins_reg.supply_present      <= 1'b1;
			pins_d_reg                   <= '0;
			pins_d_reg.supply_present    <= 1'b1;
		end else begin
			pins_meta_reg <= pins_async;
			pins_reg      <= pins_meta_reg;
			pins_d_reg    <= pins_reg;
		end
	end

	assign supply_back = pins_reg.supply_present & ~pins_d_reg.supply_present;
	assign end_cfg_evt = pins_reg.end_configuration_command & ~pins_d_reg.end_configuration_command;
	assign call_evt    = pins_reg.both_arrow_keys & ~pins_d_reg.both_arrow_keys;
	assign view_rise   = pins_reg.info_view_sel & ~pins_d_reg.info_view_sel;

	assign refresh_tick = (refresh_cnt_reg == '0) | view_rise;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			refresh_cnt_reg <= '0;
		end else if (refresh_tick) begin
			refresh_cnt_reg <= pins_reg.info_view_sel ? TMR_W'(REFRESH_CYCLES - 1) : TMR_W'(DAY_CYCLES - 1);
		end else begin
			refresh_cnt_reg <= refresh_cnt_reg - 1'b1;
		end
	end

	// flow sensor status latched only on refresh
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			flow1_reg <= '0;
			flow2_reg <= '0;
		end else if (refresh_tick) begin
			flow1_reg <= pins_reg.first_flow_sensor;
			flow2_reg <= pins_reg.second_flow_sensor;
		end
	end

	// assemble the status word; bit 0 stays clear
	always_comb begin
		word_next            = WORD_RESET;
		word_next[B_LOWBAT]  = pins_reg.low_battery;
		word_next[B_EXTALM]  = pins_reg.ext_alarm;
		word_next[B_T1_HI]   = pins_reg.temp_above[0];
		word_next[B_T2_HI]   = pins_reg.temp_above[1];
		word_next[B_T3_HI]   = pins_reg.temp_above[2];
		word_next[B_T1_LO]   = pins_reg.temp_below[0];
		word_next[B_T2_LO]   = pins_reg.temp_below[1];
		word_next[B_T3_LO]   = pins_reg.temp_below[2];
		word_next[B_DT_BAD]  = pins_reg.diff_wrong;
		word_next[B_F1_AIR]  = flow1_reg.air;
		word_next[B_F1_REV]  = flow1_reg.reverse;
		word_next[B_F1_OVR]  = flow1_reg.over_flow;
		word_next[B_F1_COM]  = flow1_reg.comm_err;
		word_next[B_F1_PUL]  = flow1_reg.pulse_fig;
		word_next[B_F2_AIR]  = flow2_reg.air;
		word_next[B_F2_REV]  = flow2_reg.reverse;
		word_next[B_F2_OVR]  = flow2_reg.over_flow;
		word_next[B_F2_COM]  = flow2_reg.comm_err;
		word_next[B_F2_PUL]  = flow2_reg.pulse_fig;
		word_next[B_BURST_LOSS] = pins_reg.burst_loss;
		word_next[B_BURST_PEN]  = pins_reg.burst_pen;
		word_next[B_LEAK_LOSS]  = pins_reg.leak_loss;
		word_next[B_LEAK_PEN]   = pins_reg.leak_pen;
		word_next[B_A1_LK]   = pins_reg.pair_a_first_input;
		word_next[B_A2_LK]   = pins_reg.pair_a_second_input;
		word_next[B_A_ALM]   = pins_reg.pair_a_alarm;
		word_next[B_B_ALM]   = pins_reg.pair_b_alarm;
		// second pair leakage gated by option
		word_next[B_B1_LK]   = pins_reg.pair_b_first_input & pins_reg.pair_b_leak_sel;
		word_next[B_B2_LK]   = pins_reg.pair_b_second_input & pins_reg.pair_b_leak_sel;
	end

	// latch word and previous word for change compare
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			word_reg      <= WORD_RESET;
			prev_word_reg <= WORD_RESET;
		end else begin
			word_reg      <= word_next;
			prev_word_reg <= word_reg;
		end
	end
	assign change_evt        = (word_reg != prev_word_reg);
	assign fault_status_word = word_reg;

	// supply loss never visible in the current word
	AST_NO_SUPPLY_BIT: assert property (!fault_status_word[B_SUPPLY])
		else $error("supply loss bit visible in status word");

	// second pair leakage needs the option
	AST_PAIR_B_GATED: assert property (!pins_reg.pair_b_leak_sel |=> !word_reg[B_B1_LK] && !word_reg[B_B2_LK])
		else $error("pair B leakage set without option");

	// Blink phase generator
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			blink_cnt_reg <= '0;
			blink_reg     <= 1'b0;
		end else if (blink_cnt_reg == '0) begin
			blink_cnt_reg <= TMR_W'(BLINK_CYCLES - 1);
			blink_reg     <= ~blink_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg - 1'b1;
		end
	end

	// flash on nonzero word; steady in current-info view
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			info_lamp <= 1'b0;
		end else begin
			info_lamp <= pins_reg.info_view_sel | ((word_reg != WORD_RESET) & blink_reg);
		end
	end

	AST_LAMP_STEADY: assert property (pins_reg.info_view_sel |=> info_lamp)
		else $error("lamp not steady in current-info view");
	AST_LAMP_DARK: assert property (!pins_reg.info_view_sel && word_reg == WORD_RESET |=> !info_lamp)
		else $error("lamp lit with clean status word");

	// transport ends on first flow; also on end command; sticky
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			transport_reg <= 1'b1;
		end else if (pins_reg.flow_min_seen | end_cfg_evt) begin
			transport_reg <= 1'b0;
		end
	end

	// sequence and configuration access follow transport
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			transport_state  <= 1'b1;
			power_saving_seq <= 1'b1;
			config_access    <= 1'b1;
		end else begin
			transport_state  <= transport_reg & ~(pins_reg.flow_min_seen | end_cfg_evt);
			power_saving_seq <= transport_reg & ~(pins_reg.flow_min_seen | end_cfg_evt);
			config_access    <= transport_reg & ~(pins_reg.flow_min_seen | end_cfg_evt);
		end
	end

	AST_TRANSPORT_STICKY: assert property (!transport_reg |=> !transport_reg)
		else $error("transport state re-entered");
	AST_END_CFG: assert property (end_cfg_evt |=> !transport_reg && !config_access)
		else $error("end command did not close transport");

	// radio on at first flow; config or forced call; not in test
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			radio_reg <= 1'b0;
		end else if (!pins_reg.test_loop && (pins_reg.flow_min_seen | pins_reg.cfg_radio_enable | call_evt)) begin
			radio_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			radio_on <= 1'b0;
		end else begin
			radio_on <= radio_reg & ~pins_reg.test_loop;
		end
	end

	AST_RADIO_TEST: assert property (pins_reg.test_loop |=> !radio_on)
		else $error("radio on in test loop");

	// count changes; zero at reset; not in transport
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			info_event_count <= 32'h00000000;
		end else if (change_evt && !transport_reg) begin
			info_event_count <= info_event_count + 32'h00000001;
		end
	end

	sequence s_counted_change;
		change_evt && !transport_reg;
	endsequence
	AST_COUNT_STEP: assert property (s_counted_change |=> info_event_count == $past(info_event_count) + 32'h1)
		else $error("event counter did not step by one");
	AST_TRANSPORT_NO_COUNT: assert property (transport_reg |=> $stable(info_event_count))
		else $error("event counter moved in transport");

	// log on change outside transport; supply return logged
	// nothing is logged while in transport, supply return included
	assign log_wr = (change_evt | supply_back) & ~transport_reg;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_ptr_reg <= 8'h00;
			log_count  <= 8'h00;
		end else if (log_wr) begin
			wr_ptr_reg <= (wr_ptr_reg == LOG_LAST) ? 8'h00 : wr_ptr_reg + 8'h01;
			log_count  <= (log_count == LOG_DEPTH_8) ? log_count : log_count + 8'h01;
		end
	end

	// record date, time, word and energies
	always_ff @(posedge clk_sys) begin
		if (log_wr) begin
			log_mem[wr_ptr_reg] <= '{stamp: now_stamp,
				info: word_reg | (32'(supply_back) << B_SUPPLY),
				heat_energy_register: heat_energy_register,
				cooling_energy_register: cooling_energy_register};
		end
	end

	// read by age, newest 50 counted for the display
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			log_rd_data    <= '0;
			log_view_count <= 8'h00;
		end else begin
			log_rd_data    <= (log_rd_age < log_count) ? log_mem[ring_back(wr_ptr_reg, log_rd_age)] : '0;
			log_view_count <= (log_count > LOG_VIEW_8) ? LOG_VIEW_8 : log_count;
		end
	end

	sequence s_logged;
		log_wr ##1 (log_count != 8'h00);
	endsequence
	AST_LOG_ON_CHANGE: assert property (change_evt && !transport_reg |-> s_logged)
		else $error("word change not logged");

	// forced serial temperatures; difference and power; diff ignored
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			temp_report  <= '{default: TEMP_FORCED_LO};
			diff_report  <= DIFF_FORCED;
			power_report <= POWER_FORCED;
		end else begin
			for (int i = 0; i < 3; i++) begin
				temp_report[i] <= pins_reg.temp_above[i] ? TEMP_FORCED_HI :
					(pins_reg.temp_below[i] ? TEMP_FORCED_LO : temp_meas[i]);
			end
			diff_report  <= (|{pins_reg.temp_above, pins_reg.temp_below}) ? DIFF_FORCED : diff_meas;
			power_report <= (|{pins_reg.temp_above, pins_reg.temp_below}) ? POWER_FORCED : power_meas;
		end
	end

	AST_TEMP_OPEN: assert property (pins_reg.temp_above[0] |=> temp_report[0] == TEMP_FORCED_HI)
		else $error("open sensor not reported as 185,00");
	AST_POWER_ZERO: assert property (pins_reg.temp_below[1] |=> power_report == POWER_FORCED && diff_report == DIFF_FORCED)
		else $error("power or difference not forced to zero");

	// blank readings and halt dependent energy accumulation
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			temp_blank    <= 3'h0;
			power_blank   <= 1'b0;
			heat_accum_en <= 1'b1;
			cool_accum_en <= 1'b1;
		end else begin
			temp_blank    <= pins_reg.temp_above | pins_reg.temp_below;
			power_blank   <= |{pins_reg.temp_above, pins_reg.temp_below};
			heat_accum_en <= ~(|{pins_reg.temp_above[1:0], pins_reg.temp_below[1:0], flow1_reg.comm_err});
			cool_accum_en <= ~(|{pins_reg.temp_above[1:0], pins_reg.temp_below[1:0], flow1_reg.comm_err});
		end
	end

	AST_DIFF_NOT_FAULT: assert property (pins_reg.diff_wrong && !(|pins_reg.temp_above) && !(|pins_reg.temp_below)
		&& !flow1_reg.comm_err |=> heat_accum_en && !power_blank)
		else $error("wrong difference treated as sensor fault");

endmodule : icsm_monitor

`default_nettype wire

// File: tb/icsm_far_end.sv
`timescale 1ns/100ps
`default_nettype none

// Stand-in for the sensor front end, keys and meter registers
module icsm_far_end
	import icsm_pkg::*;
#(
	parameter logic [31:0] HEAT_VAL = 32'h00012345,
	parameter logic [31:0] COOL_VAL = 32'h00000678
) (
	input  wire logic       clk_sys,
	input  wire icsm_pins_t pins_cmd,
	output icsm_pins_t      pins_async,
	output icsm_stamp_t     now_stamp,
	output logic [31:0]     heat_energy_register,
	output logic [31:0]     cooling_energy_register,
	output logic [15:0]     temp_meas [3],
	output logic [15:0]     diff_meas,
	output logic [23:0]     power_meas
);
	// Pin levels pass straight through; measured values stay fixed
	assign pins_async = pins_cmd;
	assign heat_energy_register = HEAT_VAL;
	assign cooling_energy_register = COOL_VAL;
	assign temp_meas[0] = 16'h1770;
	assign temp_meas[1] = 16'h0fa0;
	assign temp_meas[2] = 16'h07d0;
	assign diff_meas = 16'h07d0;
	assign power_meas = 24'h0003e8;

	// Real-time clock runs on, one step a cycle
	initial now_stamp = '0;
	always @(posedge clk_sys) begin
		now_stamp.second <= now_stamp.second + 6'h1;
	end
endmodule : icsm_far_end

`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
	import icsm_pkg::*;
	localparam logic [31:0] HEAT = 32'h00012345;
	localparam logic [31:0] COOL = 32'h00000678;
	typedef struct packed {logic [31:0] word; logic [31:0] cnt;} icsm_note_t;

	logic          clk_sys = 1'b0;
	logic          srst = 1'b1;
	icsm_pins_t    pins_cmd, pins_async, p, p0;
	icsm_stamp_t   now_stamp;
	logic [31:0]   heat_energy_register, cooling_energy_register, fault_status_word, info_event_count;
	logic [15:0]   temp_meas [3];
	logic [15:0]   temp_report [3];
	logic [15:0]   diff_meas, diff_report;
	logic [23:0]   power_meas, power_report;
	logic [7:0]    log_rd_age, log_count, log_view_count;
	logic [2:0]    temp_blank;
	logic          info_lamp, transport_state, power_saving_seq, config_access, radio_on;
	logic          power_blank, heat_accum_en, cool_accum_en, cnt_due = 1'b0, tr;
	icsm_log_rec_t log_rd_data;
	icsm_note_t    q[$], note;
	logic [31:0]   seen, due_cnt, cnt_exp, last_exp, lfsr_st = 32'hc7978f85;
	int            fails = 0, samples_checked = 0, lc, n;

	icsm_far_end far (.clk_sys, .pins_cmd, .pins_async, .now_stamp, .heat_energy_register,
		.cooling_energy_register, .temp_meas, .diff_meas, .power_meas);

	icsm_monitor #(.DAY_CYCLES(200), .REFRESH_CYCLES(20), .BLINK_CYCLES(4)) DUT (.clk_sys, .srst,
		.pins_async, .now_stamp, .heat_energy_register, .cooling_energy_register, .temp_meas, .diff_meas,
		.power_meas, .log_rd_age, .fault_status_word, .info_lamp, .info_event_count, .transport_state,
		.power_saving_seq, .config_access, .radio_on, .temp_report, .diff_report, .power_report,
		.temp_blank, .power_blank, .heat_accum_en, .cool_accum_en, .log_count, .log_view_count, .log_rd_data);

	// Clock
	always #50 clk_sys = ~clk_sys;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Expected status word for a pin set
	function automatic logic [31:0] exp_word(input icsm_pins_t x);
		icsm_flow_st_t f;
		icsm_flow_st_t s;
		logic          b;
		f = x.first_flow_sensor;
		s = x.second_flow_sensor;
		b = x.pair_b_leak_sel;
		return {x.leak_pen, x.leak_loss, x.burst_pen, x.burst_loss, s.over_flow, 1'b0, s.reverse, s.air,
			s.pulse_fig, s.comm_err, x.temp_below[2], x.temp_above[2], x.pair_b_second_input & b,
			x.pair_a_second_input, f.pulse_fig, f.comm_err, x.pair_b_alarm, x.pair_a_alarm,
			x.pair_b_first_input & b, x.pair_a_first_input, f.over_flow, 1'b0, f.reverse, f.air,
			x.diff_wrong, x.temp_below[1:0], x.temp_above[1:0], x.ext_alarm, x.low_battery, 1'b0};
	endfunction : exp_word

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// Drive a pin set, note the word it should give, wait for it
	task automatic put(input icsm_pins_t x, input int lim);
		logic [31:0] e;
		@(negedge clk_sys);
		pins_cmd = x;
		e = exp_word(x);
		if (e !== last_exp) begin
			if (!tr) begin
				cnt_exp++;
				if (lc < 250) lc++;
			end
			q.push_back('{e, cnt_exp});
			last_exp = e;
		end
		for (int i = 0; i < lim && q.size() > 0; i++) @(negedge clk_sys);
		chk("pending notes", 32'h0, 32'(q.size()));
		// Pin to radio_on takes four rising edges
		repeat (4) @(negedge clk_sys);
	endtask : put

	task automatic do_reset();
		@(negedge clk_sys);
		srst = 1'b1;
		pins_cmd = p0;
		repeat (4) @(negedge clk_sys);
		srst = 1'b0;
		q.delete();
		cnt_exp = '0;
		last_exp = '0;
		lc = 0;
		tr = 1'b1;
	endtask : do_reset

	task automatic lamp_ones();
		n = 0;
		repeat (12) begin
			@(negedge clk_sys);
			n += int'(info_lamp === 1'b1);
		end
	endtask : lamp_ones

	// Output watcher: pairs each new status word with the oldest note
	always @(negedge clk_sys) begin
		if (cnt_due) begin
			chk("event count", due_cnt, info_event_count);
			cnt_due = 1'b0;
		end
		if (srst)
			seen = '0;
		else if (fault_status_word !== seen) begin
			seen = fault_status_word;
			if (q.size() == 0) begin
				fails++;
				$display("Error status word expected none seen %h", seen);
			end else begin
				note = q.pop_front();
				chk("status word", note.word, seen);
				due_cnt = note.cnt;
				cnt_due = 1'b1;
			end
		end
	end

	// Watchdog
	initial begin
		repeat (30000) @(posedge clk_sys);
		fails++;
		stop_test();
	end

	// Main sequence
	initial begin
		p0 = '0;
		p0.supply_present = 1'b1;
		pins_cmd = p0;
		log_rd_age = 8'h00;
		do_reset();
		chk("event count", 32'h0, info_event_count);
		chk("transport", 32'h1, 32'(transport_state));
		chk("power saving", 32'h1, 32'(power_saving_seq));
		chk("config access", 32'h1, 32'(config_access));
		chk("radio", 32'h0, 32'(radio_on));
		p = p0;
		p.temp_below[0] = 1'b1;
		p.temp_above[1] = 1'b1;
		put(p, 10);
		chk("temp first", 32'(TEMP_FORCED_LO), 32'(temp_report[0]));
		chk("temp second", 32'(TEMP_FORCED_HI), 32'(temp_report[1]));
		chk("temp third", 32'h07d0, 32'(temp_report[2]));
		chk("difference", 32'(DIFF_FORCED), 32'(diff_report));
		chk("power", 32'(POWER_FORCED), 32'(power_report));
		chk("temp blank", 32'h3, 32'(temp_blank));
		chk("power blank", 32'h1, 32'(power_blank));
		chk("accumulation", 32'h0, 32'({heat_accum_en, cool_accum_en}));
		lamp_ones();
		chk("lamp flashing", 32'h1, 32'(n > 0 && n < 12));
		p.info_view_sel = 1'b1;
		put(p, 10);
		lamp_ones();
		chk("lamp steady", 32'hc, 32'(n));
		p = p0;
		p.diff_wrong = 1'b1;
		put(p, 10);
		chk("temp blank", 32'h0, 32'(temp_blank));
		chk("heat accumulation", 32'h1, 32'(heat_accum_en));
		p = p0;
		put(p, 10);
		lamp_ones();
		chk("lamp idle", 32'h0, 32'(n));
		p.pair_b_first_input = 1'b1;
		p.pair_b_second_input = 1'b1;
		put(p, 10);
		chk("status word", 32'h0, fault_status_word);
		p.pair_b_leak_sel = 1'b1;
		put(p, 10);
		p = p0;
		put(p, 10);
		chk("log count", 32'h0, 32'(log_count));
		p.test_loop = 1'b1;
		put(p, 5);
		p.both_arrow_keys = 1'b1;
		put(p, 5);
		chk("radio", 32'h0, 32'(radio_on));
		p.test_loop = 1'b0;
		p.both_arrow_keys = 1'b0;
		put(p, 5);
		p.both_arrow_keys = 1'b1;
		put(p, 5);
		chk("radio", 32'h1, 32'(radio_on));
		chk("transport", 32'h1, 32'(transport_state));
		p.flow_min_seen = 1'b1;
		put(p, 5);
		chk("transport", 32'h0, 32'(transport_state));
		chk("power saving", 32'h0, 32'(power_saving_seq));
		p.flow_min_seen = 1'b0;
		put(p, 5);
		chk("transport", 32'h0, 32'(transport_state));
		do_reset();
		p = p0;
		p.cfg_radio_enable = 1'b1;
		put(p, 5);
		chk("radio", 32'h1, 32'(radio_on));
		chk("transport", 32'h1, 32'(transport_state));
		p.end_configuration_command = 1'b1;
		put(p, 5);
		chk("transport", 32'h0, 32'(transport_state));
		chk("config access", 32'h0, 32'(config_access));
		p.test_loop = 1'b1;
		p.flow_min_seen = 1'b1;
		put(p, 5);
		chk("radio", 32'h0, 32'(radio_on));
		do_reset();
		p = p0;
		p.flow_min_seen = 1'b1;
		put(p, 5);
		tr = 1'b0;
		chk("radio", 32'h1, 32'(radio_on));
		chk("transport", 32'h0, 32'(transport_state));
		p.supply_present = 1'b0;
		put(p, 5);
		chk("status word", 32'h0, fault_status_word);
		p.supply_present = 1'b1;
		put(p, 5);
		lc++;
		chk("log count", 32'(lc), 32'(log_count));
		chk("log info", 32'h1, log_rd_data.info);
		p.info_view_sel = 1'b1;
		put(p, 5);
		p.second_flow_sensor.comm_err = 1'b1;
		put(p, 30);
		p.info_view_sel = 1'b0;
		put(p, 5);
		p.first_flow_sensor.air = 1'b1;
		put(p, 250);
		chk("log info", last_exp, log_rd_data.info);
		chk("log heat", HEAT, log_rd_data.heat_energy_register);
		chk("log cooling", COOL, log_rd_data.cooling_energy_register);
		repeat (260) begin
			lfsr_st = lfsr(lfsr_st);
			{p.low_battery, p.ext_alarm, p.temp_above, p.temp_below, p.diff_wrong, p.burst_loss,
				p.burst_pen, p.leak_loss, p.leak_pen, p.pair_a_first_input, p.pair_a_second_input,
				p.pair_b_first_input, p.pair_b_second_input, p.pair_a_alarm, p.pair_b_alarm,
				p.pair_b_leak_sel} = lfsr_st[19:0];
			put(p, 10);
		end
		chk("log count", 32'(LOG_DEPTH), 32'(log_count));
		chk("log view count", 32'(LOG_VIEW), 32'(log_view_count));
		chk("log info", last_exp, log_rd_data.info);
		log_rd_age = 8'hfa;
		repeat (2) @(negedge clk_sys);
		chk("log beyond depth", 32'h0, log_rd_data.info);
		stop_test();
	end
endmodule : tb

`default_nettype wire
